// [hw/serial_input_signal_conditioning.sv]
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ns
module serial_input_signal_conditioning
    import serial_in_cond_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              srst,
    // axi4-lite slave
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // serial line
    input  wire logic              rx_data_in,
    input  wire logic              ctl_in,
    // toward the data shift unit
    output logic                   shift_data,
    output logic                   shift_ctl,
    output logic                   data_trigger,
    output logic                   irq
);

    ////////////////////////////////////////////////////////////////////////////
    // register state
    in_cfg_s           data_cfg_q;
    in_cfg_s           ctl_cfg_q;
    logic [INT_W-1:0]  int_status_q;
    logic [INT_W-1:0]  int_status_d;
    logic [INT_W-1:0]  int_mask_q;

    logic [ADDR_W-1:0] aw_addr_q;
    logic              aw_have_q;
    logic [31:0]       w_data_q;
    logic [3:0]        w_strb_q;
    logic              w_have_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              rvalid_q;
    logic [31:0]       rdata_q;
    logic [1:0]        rresp_q;

    ////////////////////////////////////////////////////////////////////////////
    // conditioning paths
    logic data_sync;
    logic ctl_sync;
    logic ctl_change;
    in_cfg_s ctl_path_cfg;

    assign ctl_path_cfg = '{edge_mode: EDGE_BOTH, invert: ctl_cfg_q.invert,
                            sync_sel: ctl_cfg_q.sync_sel};

    input_conditioner #(
        .STAGES   (SYNC_STAGES)
    ) u_data_cond (
        .clk      (clk),
        .srst     (srst),
        .raw_in   (rx_data_in),
        .cfg      (data_cfg_q),
        .cond_out (shift_data),
        .sync_out (data_sync),
        .trig     (data_trigger)
    );

    input_conditioner #(
        .STAGES   (SYNC_STAGES)
    ) u_ctl_cond (
        .clk      (clk),
        .srst     (srst),
        .raw_in   (ctl_in),
        .cfg      (ctl_path_cfg),
        .cond_out (shift_ctl),
        .sync_out (ctl_sync),
        .trig     (ctl_change)
    );

    ////////////////////////////////////////////////////////////////////////////
    // write channel decode
    logic        wr_fire;
    logic        wr_data_hit;
    logic        wr_ctl_hit;
    logic        wr_stat_hit;
    logic        wr_mask_hit;
    logic        wr_map_hit;
    logic [31:0] wr_word;

    assign s_axi_awready = !aw_have_q && !bvalid_q;
    assign s_axi_wready  = !w_have_q && !bvalid_q;
    assign wr_fire       = aw_have_q && w_have_q && !bvalid_q;
    assign wr_word       = w_strb_q[0] ? w_data_q : 32'h0000_0000;
    assign wr_data_hit   = wr_fire && w_strb_q[0] && aw_addr_q == DATA_CFG_OFS;
    assign wr_ctl_hit    = wr_fire && w_strb_q[0] && aw_addr_q == CTL_CFG_OFS;
    assign wr_stat_hit   = wr_fire && aw_addr_q == INT_STATUS_OFS;
    assign wr_mask_hit   = wr_fire && w_strb_q[0] && aw_addr_q == INT_MASK_OFS;
    assign wr_map_hit    = aw_addr_q == DATA_CFG_OFS || aw_addr_q == CTL_CFG_OFS ||
                           aw_addr_q == INT_STATUS_OFS || aw_addr_q == INT_MASK_OFS;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            aw_addr_q <= '0;
            aw_have_q <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_addr_q <= s_axi_awaddr;
            aw_have_q <= 1'b1;
        end else if (wr_fire) begin
            aw_have_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            w_have_q <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
            w_have_q <= 1'b1;
        end else if (wr_fire) begin
            w_have_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_map_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration and interrupt registers
    always_ff @(posedge clk) begin
        if (srst) begin
            data_cfg_q <= cfg_from_word(CFG_RESET, 1'b1);
            ctl_cfg_q  <= cfg_from_word(CFG_RESET, 1'b0);
            int_mask_q <= INT_RESET;
        end else begin
            if (wr_data_hit) data_cfg_q <= cfg_from_word(wr_word, 1'b1);
            if (wr_ctl_hit)  ctl_cfg_q  <= cfg_from_word(wr_word, 1'b0);
            if (wr_mask_hit) int_mask_q <= wr_word[INT_W-1:0];
        end
    end

    // event set wins over a write-one clear in the same cycle
    always_comb begin
        int_status_d = int_status_q;
        if (wr_stat_hit && w_strb_q[0]) begin
            int_status_d = int_status_q & ~w_data_q[INT_W-1:0];
        end
        int_status_d[INT_DATA_BIT] = int_status_d[INT_DATA_BIT] | data_trigger;
        int_status_d[INT_CTL_BIT]  = int_status_d[INT_CTL_BIT] | ctl_change;
    end

    always_ff @(posedge clk) begin
        if (srst) int_status_q <= INT_RESET;
        else      int_status_q <= int_status_d;
    end

    assign irq = |(int_status_q & int_mask_q);

    ////////////////////////////////////////////////////////////////////////////
    // read channel
    logic [31:0] rd_word;
    logic        rd_map_hit;

    always_comb begin
        rd_word    = 32'h0000_0000;
        rd_map_hit = 1'b1;
        case (s_axi_araddr)
            DATA_CFG_OFS:   rd_word = cfg_word(data_cfg_q);
            CTL_CFG_OFS:    rd_word = cfg_word(ctl_cfg_q);
            INT_STATUS_OFS: rd_word[INT_W-1:0] = int_status_q;
            INT_MASK_OFS:   rd_word[INT_W-1:0] = int_mask_q;
            default:        rd_map_hit = 1'b0;
        endcase
    end

    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_word;
            rresp_q  <= rd_map_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence data_sync_steady;
        (data_cfg_q.sync_sel && $stable(data_cfg_q.invert)) [*3];
    endsequence

    sequence data_raw_steady;
        !data_cfg_q.sync_sel [*1];
    endsequence

    sequence write_pending;
        bvalid_q && !s_axi_bready;
    endsequence

    sequence read_pending;
        rvalid_q && !s_axi_rready;
    endsequence

    chk_data_sync_path: assert property (
        data_sync_steady |-> shift_data == ($past(rx_data_in, 2) ^ data_cfg_q.invert))
        else $error("shift data does not follow the two stage copy");

    chk_data_raw_path: assert property (
        data_raw_steady |-> shift_data == (rx_data_in ^ data_cfg_q.invert))
        else $error("raw data path not inverted as configured");

    chk_ctl_raw_path: assert property (
        !ctl_cfg_q.sync_sel |-> shift_ctl == (ctl_in ^ ctl_cfg_q.invert))
        else $error("raw control path not inverted as configured");

    chk_ctl_sync_path: assert property (
        ((ctl_cfg_q.sync_sel && $stable(ctl_cfg_q.invert)) [*3])
        |-> shift_ctl == ($past(ctl_in, 2) ^ ctl_cfg_q.invert))
        else $error("shift control does not follow the two stage copy");

    chk_trig_sets_status: assert property (
        data_trigger |=> int_status_q[INT_DATA_BIT])
        else $error("data trigger lost from status");

    chk_irq_masked: assert property (
        (data_trigger && int_mask_q[INT_DATA_BIT] && !wr_mask_hit) |=> irq)
        else $error("unmasked data event did not raise the interrupt");

    chk_edge_cfg_write: assert property (
        wr_data_hit |=> data_cfg_q.edge_mode == edge_mode_e'($past(wr_word[EDGE_LSB+1:EDGE_LSB])))
        else $error("edge field not stored");

    chk_read_latency: assert property (
        (s_axi_arvalid && s_axi_arready) |=> rvalid_q)
        else $error("read answer not one cycle after address");

    chk_write_answer: assert property (
        wr_fire |=> bvalid_q)
        else $error("write answer not one cycle after both halves");

    chk_bvalid_holds: assert property (
        write_pending |=> (bvalid_q && $stable(bresp_q)))
        else $error("write response dropped before it was taken");

    chk_rvalid_holds: assert property (
        read_pending |=> (rvalid_q && $stable(rdata_q) && $stable(rresp_q)))
        else $error("read response dropped before it was taken");

    chk_unmapped_write: assert property (
        (wr_fire && !wr_map_hit) |=> bresp_q == RESP_SLVERR)
        else $error("unmapped write not answered with an error");

    chk_status_clear: assert property (
        (wr_stat_hit && w_strb_q[0] && w_data_q[INT_DATA_BIT] && !data_trigger)
        |=> !int_status_q[INT_DATA_BIT])
        else $error("write one did not clear the data status bit");

    chk_ctl_change_sets: assert property (
        ctl_change |=> int_status_q[INT_CTL_BIT])
        else $error("control change lost from status");

    chk_ctl_edge_both: assert property (
        $changed(ctl_sync) |-> ctl_change)
        else $error("control change not flagged on a synchronised edge");

    chk_trig_sync_edge: assert property (
        data_trigger |-> $changed(data_sync))
        else $error("data trigger without a synchronised edge");

endmodule

// [hw/serial_in_cond_pkg.sv]
package serial_in_cond_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register map (byte addresses)
    localparam logic [7:0]  DATA_CFG_OFS   = 8'h10;
    localparam logic [7:0]  CTL_CFG_OFS    = 8'h20;
    localparam logic [7:0]  INT_STATUS_OFS = 8'h30;
    localparam logic [7:0]  INT_MASK_OFS   = 8'h34;
    localparam int          ADDR_W         = 8;

    ////////////////////////////////////////////////////////////////////////////
    // field positions and reset values
    localparam int          EDGE_LSB       = 3;
    localparam int          INV_BIT        = 2;
    localparam int          SYNC_BIT       = 0;
    localparam int          INT_DATA_BIT   = 0;
    localparam int          INT_CTL_BIT    = 1;
    localparam int          INT_W          = 2;
    localparam logic [31:0] CFG_RESET      = 32'h0000_0000;
    localparam logic [1:0]  INT_RESET      = 2'h0;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;
    localparam int          SYNC_STAGES    = 2;

    ////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [1:0] {
        EDGE_OFF,
        EDGE_RISE,
        EDGE_FALL,
        EDGE_BOTH
    } edge_mode_e;

    typedef struct packed {
        edge_mode_e edge_mode;
        logic       invert;
        logic       sync_sel;
    } in_cfg_s;

    ////////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic edge_hit(input edge_mode_e m, input logic prev, input logic cur);
        case (m)
            EDGE_RISE: edge_hit = !prev && cur;
            EDGE_FALL: edge_hit = prev && !cur;
            EDGE_BOTH: edge_hit = prev != cur;
            default:   edge_hit = 1'b0;
        endcase
    endfunction

    function automatic logic [31:0] cfg_word(input in_cfg_s c);
        cfg_word = 32'h0000_0000;
        cfg_word[EDGE_LSB+1:EDGE_LSB] = c.edge_mode;
        cfg_word[INV_BIT] = c.invert;
        cfg_word[SYNC_BIT] = c.sync_sel;
    endfunction

    function automatic in_cfg_s cfg_from_word(input logic [31:0] w, input logic has_edge);
        cfg_from_word.edge_mode = has_edge ? edge_mode_e'(w[EDGE_LSB+1:EDGE_LSB]) : EDGE_OFF;
        cfg_from_word.invert = w[INV_BIT];
        cfg_from_word.sync_sel = w[SYNC_BIT];
    endfunction

endpackage

// [hw/input_conditioner.sv]
`timescale 1ns/1ns
module input_conditioner
    import serial_in_cond_pkg::*;
#(
    parameter int STAGES = SYNC_STAGES
) (
    input  wire logic    clk,
    input  wire logic    srst,
    input  wire logic    raw_in,
    input  wire in_cfg_s cfg,
    output logic         cond_out,
    output logic         sync_out,
    output logic         trig
);

    logic [STAGES-1:0] sync_q;
    logic              prev_q;
    logic              inv_in;

    ////////////////////////////////////////////////////////////////////////////
    // inversion ahead of the synchroniser
    assign inv_in   = raw_in ^ cfg.invert;
    assign sync_out = sync_q[STAGES-1];
    assign cond_out = cfg.sync_sel ? sync_out : inv_in;
    assign trig     = edge_hit(cfg.edge_mode, prev_q, sync_out);

    always_ff @(posedge clk) begin
        if (srst) begin
            sync_q <= '0;
            prev_q <= 1'b0;
        end else begin
            sync_q <= {sync_q[STAGES-2:0], inv_in};
            prev_q <= sync_out;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    chk_sync_two_stage: assert property (
        !$past(srst, 2) |-> sync_out == $past(inv_in, 2))
        else $error("sync path is not two stages of the inverted input");

    chk_edge_off_quiet: assert property (
        cfg.edge_mode == EDGE_OFF |-> !trig)
        else $error("trigger raised while edge detection is off");

    chk_edge_rise_fires: assert property (
        (cfg.edge_mode == EDGE_RISE && $rose(sync_out)) |-> trig)
        else $error("rising edge missed");

    chk_edge_fall_only: assert property (
        (cfg.edge_mode == EDGE_FALL && trig) |-> $fell(sync_out))
        else $error("falling mode fired without a falling edge");

endmodule

// [test/serial_line_model.sv]
`timescale 1ns/1ns
module serial_line_model (
    input  wire logic clk,
    output logic      rx_data_in,
    output logic      ctl_in
);
    ////////////////////////////////////////////////////////////////////////////
    // idle serial line sits high
    initial begin
        rx_data_in = 1'b1;
        ctl_in     = 1'b1;
    end

    // new levels land just after a rising edge
    task automatic drive(input logic d, input logic c);
        @(posedge clk);
        rx_data_in <= d;
        ctl_in     <= c;
    endtask
endmodule

// [test/serial_input_signal_conditioning_tb.sv]
`timescale 1ns/1ns
module serial_input_signal_conditioning_tb;
    import serial_in_cond_pkg::*;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'hf;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic        rx, ctl, shift_data, shift_ctl, data_trigger, irq;
    logic [31:0] rd;
    logic [1:0]  rs;
    int          bad_count = 0;
    int          total_checks = 0;
    int          cyc = 0;
    int          k;

    always #25 clk = ~clk;

    serial_line_model line (.clk(clk), .rx_data_in(rx), .ctl_in(ctl));

    serial_input_signal_conditioning DUT (
        .clk(clk), .srst(srst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx_data_in(rx), .ctl_in(ctl),
        .shift_data(shift_data), .shift_ctl(shift_ctl), .data_trigger(data_trigger),
        .irq(irq)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count = bad_count + 1;
            tally_and_finish;
        end
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks = total_checks + 1;
        if (g !== e) begin
            bad_count = bad_count + 1;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // bus cycles
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw, w, ta, tw, b;
        aw = 1'b1;
        w = 1'b1;
        b = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (aw || w) begin
            @(negedge clk);
            ta = aw && awready;
            tw = w && wready;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            aw = aw && !ta;
            w = w && !tw;
        end
        bready <= 1'b1;
        while (!b) begin
            @(negedge clk);
            b = bvalid;
            r = bresp;
            @(posedge clk);
        end
        bready <= 1'b0;
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic t;
        t = 1'b0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!t) begin
            @(negedge clk);
            t = arready;
            @(posedge clk);
        end
        arvalid <= 1'b0;
        t = 1'b0;
        while (!t) begin
            @(negedge clk);
            t = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk);
        end
        rready <= 1'b0;
    endtask

    task automatic count_trig(output int n);
        n = 0;
        repeat (6) begin
            @(negedge clk);
            if (data_trigger === 1'b1) n = n + 1;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic regs_test;
        axr(8'h10, rd, rs);
        chk("data_cfg reset", 32'h0, rd);
        axr(8'h20, rd, rs);
        chk("ctl_cfg reset", 32'h0, rd);
        axw(8'h10, 32'hffff_ffff, rs);
        chk("mapped bresp", {30'h0, RESP_OKAY}, {30'h0, rs});
        axr(8'h10, rd, rs);
        chk("mapped rresp", {30'h0, RESP_OKAY}, {30'h0, rs});
        chk("data_cfg fields", 32'h0000_001d, rd);
        wstrb <= 4'h0;
        axw(8'h10, 32'h0, rs);
        wstrb <= 4'hf;
        axr(8'h10, rd, rs);
        chk("strobe off keeps", 32'h0000_001d, rd);
        axw(8'h20, 32'hffff_ffff, rs);
        axr(8'h20, rd, rs);
        chk("ctl_cfg fields", 32'h0000_0005, rd);
        axr(8'h40, rd, rs);
        chk("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, rs});
        chk("unmapped rdata", 32'h0, rd);
        axw(8'h44, 32'h1, rs);
        chk("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, rs});
    endtask

    task automatic edge_test;
        for (int m = 0; m < 4; m++) begin
            axw(8'h10, 32'(m << 3) | 32'h1, rs);
            line.drive(1'b0, 1'b1);
            count_trig(k);
            chk("falling triggers", {31'h0, m[1]}, 32'(k));
            line.drive(1'b1, 1'b1);
            count_trig(k);
            chk("rising triggers", {31'h0, m[0]}, 32'(k));
        end
    endtask

    task automatic path_test(input logic is_ctl, input logic [7:0] a);
        logic v, g;
        axw(a, 32'h4, rs);
        for (int i = 0; i < 2; i++) begin
            v = i[0];
            if (is_ctl) line.drive(1'b1, v);
            else line.drive(v, 1'b1);
            @(negedge clk);
            g = is_ctl ? shift_ctl : shift_data;
            chk("raw inverted", {31'h0, ~v}, {31'h0, g});
        end
        axw(a, 32'h5, rs);
        if (is_ctl) line.drive(1'b1, 1'b0);
        else line.drive(1'b0, 1'b1);
        for (int j = 1; j < 4; j++) begin
            @(negedge clk);
            g = is_ctl ? shift_ctl : shift_data;
            chk("sync delay", {31'h0, j == 3}, {31'h0, g});
        end
        line.drive(1'b1, 1'b1);
        repeat (4) @(negedge clk);
    endtask

    task automatic irq_test;
        axw(8'h10, 32'h11, rs);
        axw(INT_STATUS_OFS, 32'h3, rs);
        axw(INT_MASK_OFS, 32'h1, rs);
        chk("irq idle", 32'h0, {31'h0, irq});
        line.drive(1'b0, 1'b0);
        repeat (5) @(negedge clk);
        chk("irq raised", 32'h1, {31'h0, irq});
        axr(INT_STATUS_OFS, rd, rs);
        chk("status bits", 32'h3, rd);
        axw(INT_STATUS_OFS, 32'h1, rs);
        @(negedge clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        axw(INT_MASK_OFS, 32'h0, rs);
        line.drive(1'b1, 1'b1);
        line.drive(1'b0, 1'b1);
        repeat (5) @(negedge clk);
        chk("irq masked", 32'h0, {31'h0, irq});
        axr(INT_STATUS_OFS, rd, rs);
        chk("status masked", 32'h3, rd);
    endtask

    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        regs_test;
        edge_test;
        path_test(1'b0, 8'h10);
        path_test(1'b1, 8'h20);
        irq_test;
        tally_and_finish;
    end
endmodule
